/* core/adc_ready_params.svh */
// Offsets, field positions and reset values of the conversion-ready status block
`ifndef ADC_READY_PARAMS_SVH
`define ADC_READY_PARAMS_SVH

// Byte offsets on the register bus
`define OFS_READY_LOW 4'h0
`define OFS_READY_HIGH 4'h4
`define OFS_QUEUE_STATUS 4'h8

// Input counts
`define NUM_INPUTS 45
`define NUM_HIGH_INPUTS 13

// Result queue status field positions
`define QS_ENABLE_BIT 31
`define QS_CAPTURE_MSB 28
`define QS_CAPTURE_LSB 24
`define QS_IRQ_EN_BIT 23
`define QS_READY_BIT 22
`define QS_OVERFLOW_BIT 21
`define QS_COUNT_MSB 15
`define QS_COUNT_LSB 8
`define QS_SIGN_BIT 7
`define QS_SOURCE_MSB 2
`define QS_SOURCE_LSB 0

// Reset values
`define READY_RESET 45'h0
`define CAPTURE_RESET 5'h00
`define WORD_RESET 32'h0000_0000

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* core/adc_ready_pkg.sv */
// Types shared by the conversion-ready status block
package adc_ready_pkg;

  // Register selected by a bus address
  typedef enum logic [1:0]
  {
    SEL_LOW = 2'b00,
    SEL_HIGH = 2'b01,
    SEL_QUEUE = 2'b10,
    SEL_NONE = 2'b11
  } reg_sel_t;

  // State of the result queue, supplied by the queue storage
  typedef struct packed
  {
    logic [7:0] count;
    logic sign;
    logic [2:0] source;
    logic overflow_evt;
    logic output_read;
  } queue_info_t;

  // Software-written queue controls
  typedef struct packed
  {
    logic enable;
    logic [4:0] capture;
    logic irq_enable;
  } queue_ctrl_t;

endpackage

/* core/adc_ready_fifo_status.sv */
// Conversion-ready flags and result queue status behind an AXI4-Lite slave
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "adc_ready_params.svh"

// How it works
// - New result sets that input's ready flag
// - Reading an input's result clears its flag
// - Low register shows inputs 0 to 31
// - High register shows inputs 32 to 44
// - High register bits 31 to 13 zero
// - Queue ready holds until read and empty
// - Interrupt enable gates queue ready interrupt
// - Overflow sets on overflow, clears on read
// - Count field shows queue entries held
module adc_ready_fifo_status
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Converter and result register events, one bit per input
  input wire logic [`NUM_INPUTS-1:0] result_written,
  input wire logic [`NUM_INPUTS-1:0] result_read,
  // Result queue
  input wire adc_ready_pkg::queue_info_t queue_info,
  output adc_ready_pkg::queue_ctrl_t queue_ctrl,
  output logic queue_irq
);
  import adc_ready_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by read and write paths
  function automatic reg_sel_t decode(input logic [3:0] addr);
    case (addr)
      `OFS_READY_LOW: decode = SEL_LOW;
      `OFS_READY_HIGH: decode = SEL_HIGH;
      `OFS_QUEUE_STATUS: decode = SEL_QUEUE;
      default: decode = SEL_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [`NUM_INPUTS-1:0] ready_r, ready_nxt;
  queue_ctrl_t ctrl_r, ctrl_nxt;
  logic qrdy_r, qrdy_nxt;
  logic ovf_r, ovf_nxt;
  logic irq_r, irq_nxt;
  logic aw_held_r, aw_held_nxt;
  logic w_held_r, w_held_nxt;
  logic [3:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] queue_word;
  logic do_write;
  logic ar_take;

  // One write and one read in flight; a new request waits for the response
  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign ar_take = arvalid && arready;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  // Live view of the queue status word
  always_comb
  begin
    queue_word = `WORD_RESET;
    queue_word[`QS_ENABLE_BIT] = ctrl_r.enable;
    queue_word[`QS_CAPTURE_MSB:`QS_CAPTURE_LSB] = ctrl_r.capture;
    queue_word[`QS_IRQ_EN_BIT] = ctrl_r.irq_enable;
    queue_word[`QS_READY_BIT] = qrdy_r;
    queue_word[`QS_OVERFLOW_BIT] = ovf_r;
    queue_word[`QS_COUNT_MSB:`QS_COUNT_LSB] = queue_info.count;
    queue_word[`QS_SIGN_BIT] = queue_info.sign;
    queue_word[`QS_SOURCE_MSB:`QS_SOURCE_LSB] = queue_info.source;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for bus and status
  always_comb
  begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt = ctrl_r;
    // Address and data may arrive in either order
    if (awvalid && awready)
    begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (wvalid && wready)
    begin
      w_held_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    // Only the queue controls take writes; ready flags ignore them
    if (do_write)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `RESP_OKAY;
      case (decode(awaddr_r))
        SEL_QUEUE:
        begin
          if (wstrb_r[3])
          begin
            ctrl_nxt.enable = wdata_r[`QS_ENABLE_BIT];
            ctrl_nxt.capture = wdata_r[`QS_CAPTURE_MSB:`QS_CAPTURE_LSB];
          end
          if (wstrb_r[2])
          begin
            ctrl_nxt.irq_enable = wdata_r[`QS_IRQ_EN_BIT];
          end
        end
        SEL_LOW, SEL_HIGH: bresp_nxt = `RESP_OKAY;
        default: bresp_nxt = `RESP_SLVERR;
      endcase
    end
    if (bvalid_r && bready)
    begin
      bvalid_nxt = 1'b0;
    end
    // Read data is captured at the address handshake
    if (rvalid_r && rready)
    begin
      rvalid_nxt = 1'b0;
    end
    if (ar_take)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `RESP_OKAY;
      case (decode(araddr))
        SEL_LOW: rdata_nxt = ready_r[31:0];
        SEL_HIGH: rdata_nxt = {19'h0, ready_r[`NUM_INPUTS-1:32]};
        SEL_QUEUE: rdata_nxt = queue_word;
        default:
        begin
          rdata_nxt = `WORD_RESET;
          rresp_nxt = `RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the hardware flags; a set beats a same-cycle clear
  always_comb
  begin
    // Status register reads leave the ready flags alone; only a queue status read clears overflow
    ready_nxt = (ready_r & ~result_read) | result_written;
    qrdy_nxt = qrdy_r;
    if (queue_info.count != 8'h00)
    begin
      qrdy_nxt = 1'b1;
    end
    else if (queue_info.output_read)
    begin
      qrdy_nxt = 1'b0;
    end
    ovf_nxt = ovf_r;
    if (ar_take && decode(araddr) == SEL_QUEUE)
    begin
      ovf_nxt = 1'b0;
    end
    if (queue_info.overflow_evt)
    begin
      ovf_nxt = 1'b1;
    end
    // Level interrupt follows the ready flag while enabled
    irq_nxt = ctrl_r.irq_enable && qrdy_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ready_r <= `READY_RESET;
      ctrl_r <= '0;
      qrdy_r <= 1'b0;
      ovf_r <= 1'b0;
      irq_r <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= `WORD_RESET;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= `WORD_RESET;
      rresp_r <= `RESP_OKAY;
    end
    else
    begin
      ready_r <= ready_nxt;
      ctrl_r <= ctrl_nxt;
      qrdy_r <= qrdy_nxt;
      ovf_r <= ovf_nxt;
      irq_r <= irq_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Outputs straight from flops
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign queue_ctrl = ctrl_r;
  assign queue_irq = irq_r;

endmodule // adc_ready_fifo_status

/* verification/adc_ready_fifo_status_asserts.sv */
// Checker for the ready flags and queue status of the status block
`timescale 1ns/1ps
`include "adc_ready_params.svh"
module adc_ready_fifo_status_asserts
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [3:0] araddr,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  // Events and queue
  input wire logic [`NUM_INPUTS-1:0] result_written,
  input wire logic [`NUM_INPUTS-1:0] result_read,
  input wire adc_ready_pkg::queue_info_t queue_info,
  input wire adc_ready_pkg::queue_ctrl_t queue_ctrl,
  input wire logic queue_irq
);
  import adc_ready_pkg::*;
  logic rd_lo;
  logic rd_hi;
  logic rd_q;
  // Read address taken, per register
  assign rd_lo = arvalid && arready && araddr == 4'h0;
  assign rd_hi = arvalid && arready && araddr == 4'h4;
  assign rd_q = arvalid && arready && araddr == 4'h8;
  // Reference flags kept from the set and clear events; a set beats a clear
  logic [`NUM_INPUTS-1:0] flags_m;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_m <= '0;
    end
    else
    begin
      flags_m <= (flags_m & ~result_read) | result_written;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////////
  // Flag registers, read data lags the taken address by one cycle
  property p_set; result_written[0] ##1 rd_lo |=> rdata[0]; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_clr; result_read[0] && !result_written[0] ##1 rd_lo |=> !rdata[0]; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_high; rd_hi |=> rdata[12:0] == $past(flags_m[`NUM_INPUTS-1:32]); endproperty
  a_high: assert property (p_high) else $error("high flag wrong");
  property p_zero; rd_hi |=> rdata[31:13] == 19'h0; endproperty
  a_zero: assert property (p_zero) else $error("high bits set");
  //////////////////////////////////////////////////////////////////////////////
  // Queue status; count is a live level sampled at the taken edge
  property p_count; rd_q |=> rdata[15:8] == $past(queue_info.count); endproperty
  a_count: assert property (p_count) else $error("count wrong");
  property p_rdy; $past(aresetn) && $past(queue_info.count) != 8'h00 && rd_q |=> rdata[22]; endproperty
  a_rdy: assert property (p_rdy) else $error("queue ready low");
  property p_ovf; queue_info.overflow_evt ##[1:2] rd_q |=> rdata[21]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missing");
  property p_irq_off; !$past(queue_ctrl.irq_enable) |-> !queue_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while off");
  property p_irq_on; queue_ctrl.irq_enable && queue_info.count != 8'h00 |-> ##[1:3] queue_irq; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  // Main scenarios reached
  c_ovf: cover property (rd_q ##1 rdata[21]);
  c_irq: cover property ($rose(queue_irq));
  c_wr: cover property (bvalid && bready);
endmodule // adc_ready_fifo_status_asserts

bind adc_ready_fifo_status adc_ready_fifo_status_asserts adc_ready_fifo_status_asserts_i
(
  .aclk(aclk),
  .aresetn(aresetn),
  .arvalid(arvalid),
  .arready(arready),
  .araddr(araddr),
  .rdata(rdata),
  .bvalid(bvalid),
  .bready(bready),
  .result_written(result_written),
  .result_read(result_read),
  .queue_info(queue_info),
  .queue_ctrl(queue_ctrl),
  .queue_irq(queue_irq)
);

/* verification/adc_ready_fifo_status_tb_top.sv */
// Self-checking bench for the conversion-ready status block
`timescale 1ns/1ps
`include "adc_ready_params.svh"
module adc_ready_fifo_status_tb_top;
  import adc_ready_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, queue_irq;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [`NUM_INPUTS-1:0] result_written, result_read;
  queue_info_t queue_info;
  queue_ctrl_t queue_ctrl;
  int fails = 0;
  int n_checks = 0;
  adc_ready_fifo_status adc_ready_fifo_status_i
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .result_written(result_written),
    .result_read(result_read),
    .queue_info(queue_info),
    .queue_ctrl(queue_ctrl),
    .queue_irq(queue_irq)
  );
  // 20 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Read and compare data and response; no latency assumed, the watchdog ends a hang
  task automatic rc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
    // Let an edge pass so a following call never reassigns rready in this step
    @(posedge aclk);
  endtask
  // Write a full word, address and data offered together; the watchdog ends a hang
  task automatic wc(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    // Let an edge pass so a following call never reassigns bready in this step
    @(posedge aclk);
  endtask
  // One-cycle result events
  task automatic pulse(input logic [44:0] w, input logic [44:0] r);
    result_written <= w;
    result_read <= r;
    @(posedge aclk);
    result_written <= '0;
    result_read <= '0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_flags();
    pulse(45'h100180000001, '0);
    rc(4'h0, 32'h80000001, 2'h0);
    rc(4'h4, 32'h00001001, 2'h0);
    rc(4'h0, 32'h80000001, 2'h0);
    pulse('0, 45'h100000000001);
    rc(4'h0, 32'h80000000, 2'h0);
    wc(4'h4, 32'hFFFFFFFF, 2'h0);
    rc(4'h4, 32'h00000001, 2'h0);
  endtask
  task automatic t_queue();
    wc(4'h8, 32'h9F800000, 2'h0);
    chk({25'h0, queue_ctrl}, 32'h0000007F);
    queue_info <= {8'h03, 1'b1, 3'h5, 2'b00};
    repeat (3) @(posedge aclk);
    chk({31'h0, queue_irq}, 32'h1);
    rc(4'h8, 32'h9FC00385, 2'h0);
    queue_info.overflow_evt <= 1'b1;
    @(posedge aclk);
    queue_info.overflow_evt <= 1'b0;
    rc(4'h8, 32'h9FE00385, 2'h0);
    rc(4'h8, 32'h9FC00385, 2'h0);
    queue_info <= {8'h00, 1'b0, 3'h0, 2'b01};
    @(posedge aclk);
    queue_info.output_read <= 1'b0;
    rc(4'h8, 32'h9F800000, 2'h0);
    rc(4'hC, 32'h0, 2'h2);
    // Unmapped write is refused and leaves the controls alone
    wc(4'hC, 32'h00000000, 2'h2);
    chk({25'h0, queue_ctrl}, 32'h0000007F);
    chk({31'h0, queue_irq}, 32'h0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence, reset held ten cycles
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    {result_written, result_read, queue_info} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(4'h0, 32'h0, 2'h0);
    rc(4'h4, 32'h0, 2'h0);
    rc(4'h8, 32'h0, 2'h0);
    t_flags();
    t_queue();
    end_of_test();
  end
  // Watchdog, far beyond the fewer than a hundred cycles the tests need
  initial
  begin
    repeat (3000) @(posedge aclk);
    fails++;
    end_of_test();
  end
endmodule // adc_ready_fifo_status_tb_top
